// [mmdir_indirect_regs.sv]
// What this block does
// RULE1: manager writes 0x001F, then pointer value
// RULE2: address mode writes overwrite the pointer
// RULE3: address mode reads return the pointer
// RULE4: 0x401F routes data accesses to pointed register
// RULE5: no-increment writes rewrite same register
// RULE6: no-increment reads return same register
// RULE7: increment modes: write stores, pointer advances
// RULE8: function 10 reads return, then advance
// RULE9: manager may skip pointer setup if valid
// RULE10: function bits 15:14, device 4:0, others ignored
// RULE11: function 11 reads leave pointer alone
// RULE12: indirect hits on control registers ignored
// RULE13: address mode reads have no side effect
// RULE14: pointer steps by one, after the access
`timescale 1ns/100ps

module mmdir_indirect_regs
#(
    parameter int EXT_WORDS = 32   // extended words held in flip-flops
)
(
    input  wire logic        i_clock,     // system clock, 100 MHz
    input  wire logic        i_reset_n,   // async reset, active low
    input  wire logic        i_mdc,       // management clock pin
    input  wire logic        i_mdio,      // management data pin, input side
    input  wire logic [4:0]  i_phy_addr,  // address strap pins
    output logic             o_mdio,      // management data pin, output side
    output logic             o_mdio_oe    // high while driving the data pin
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    localparam int IDX_W = $clog2(EXT_WORDS);

    logic [1:0]            fn_r;          // access function field
    logic [4:0]            devnum_r;      // mmd_device_number field
    logic [15:0]           ptr_r;         // extended-address pointer
    logic [15:0]           ext_r [EXT_WORDS]; // extended register storage
    logic [4:0]            strap_s1_r;    // strap sync, first stage
    logic [4:0]            strap_s2_r;    // strap sync, second stage
    logic [4:0]            phy_addr_r;    // latched own bus address
    logic [2:0]            strap_done_r;  // strap caught once after reset
    logic [15:0]           rdata;         // read answer to the frame engine
    logic                  dev_ok;        // device number selects our space
    logic                  data_hit;      // access goes to address/data register
    logic                  ptr_step;      // this access advances the pointer
    mmdir_pkg::mmdir_req_s req;           // transaction from frame engine

    ////////////////////////////////////////////////////////////////////////////
    // helpers used by both read and write paths

    // a pointer value that lands on a real storage word; the two control
    // registers themselves are never reachable through the indirect path
    function automatic logic ext_target(input logic [15:0] ptr);
        ext_target = (ptr != {11'h000, mmdir_pkg::REG_MMD_ACCESS_CONTROL}) // [RULE12]
                   && (ptr != {11'h000, mmdir_pkg::REG_MMD_ADDRESS_DATA})  // [RULE12]
                   && (ptr < EXT_WORDS[15:0]);
    endfunction

    function automatic logic [IDX_W-1:0] ext_index(input logic [15:0] ptr);
        ext_index = ptr[IDX_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial frame engine
    mmdir_mdio_slave u_mdio
    (
        .i_clock    (i_clock),
        .i_reset_n  (i_reset_n),
        .i_mdc      (i_mdc),
        .i_mdio     (i_mdio),
        .i_phy_addr (phy_addr_r),
        .i_rdata    (rdata),
        .o_mdio     (o_mdio),
        .o_mdio_oe  (o_mdio_oe),
        .o_req      (req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // strap capture: synchronised, then frozen on the first pass after release,
    // so later pin wiggles cannot move the bus address
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            strap_s1_r   <= 5'h00;
            strap_s2_r   <= 5'h00;
            phy_addr_r   <= 5'h00;
            strap_done_r <= 3'h0;
        end
        else
        begin
            strap_s1_r <= i_phy_addr;
            strap_s2_r <= strap_s1_r;
            strap_done_r <= {strap_done_r[1:0], 1'b1};
            if (strap_done_r[1] && !strap_done_r[2])
            begin
                phy_addr_r <= strap_s2_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode shared by read and write
    assign dev_ok   = (devnum_r == mmdir_pkg::DEVNUM_MMD);                      // [RULE10]
    assign data_hit = (req.reg_addr == mmdir_pkg::REG_MMD_ADDRESS_DATA) && dev_ok; // [RULE10]

    // pointer advance: writes in both increment modes, reads only in 10
    always_comb
    begin
        ptr_step = 1'b0;
        if (data_hit && req.wr)
        begin
            ptr_step = (fn_r == mmdir_pkg::FN_INC_RW)                            // [RULE7]
                     || (fn_r == mmdir_pkg::FN_INC_WR);                          // [RULE7]
        end
        else if (data_hit && req.rd)
        begin
            ptr_step = (fn_r == mmdir_pkg::FN_INC_RW);                           // [RULE8] [RULE11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read answer; the engine samples it in the cycle of the read pulse,
    // before the pointer moves on the next edge
    always_comb
    begin
        rdata = mmdir_pkg::READ_ZERO;
        case (req.reg_addr)
            mmdir_pkg::REG_MMD_ACCESS_CONTROL:
            begin
                rdata = {fn_r, {mmdir_pkg::RSVD_WIDTH{1'b0}}, devnum_r};         // [RULE10]
            end
            mmdir_pkg::REG_MMD_ADDRESS_DATA:
            begin
                if (!dev_ok)
                begin
                    rdata = mmdir_pkg::READ_ZERO;                                // [RULE10]
                end
                else if (fn_r == mmdir_pkg::FN_ADDRESS)
                begin
                    rdata = ptr_r;                                               // [RULE3] [RULE13]
                end
                else if (ext_target(ptr_r))
                begin
                    rdata = ext_r[ext_index(ptr_r)];                             // [RULE4] [RULE6] [RULE8]
                end
                else
                begin
                    rdata = mmdir_pkg::READ_ZERO;                                // [RULE12]
                end
            end
            default:
            begin
                // other direct registers belong to other blocks
                rdata = mmdir_pkg::READ_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // access-control register: written only by a direct frame
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            fn_r     <= mmdir_pkg::FN_RESET;
            devnum_r <= mmdir_pkg::DEVNUM_RESET;
        end
        else if (req.wr && (req.reg_addr == mmdir_pkg::REG_MMD_ACCESS_CONTROL))
        begin
            fn_r     <= req.wdata[mmdir_pkg::FN_HI:mmdir_pkg::FN_LO];            // [RULE10] [RULE4]
            devnum_r <= req.wdata[mmdir_pkg::DEVNUM_HI:mmdir_pkg::DEVNUM_LO];    // [RULE10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer: loaded in address mode, stepped after qualifying data accesses;
    // it persists across mode changes so setup can be skipped later
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ptr_r <= mmdir_pkg::PTR_RESET;
        end
        else if (data_hit && req.wr && (fn_r == mmdir_pkg::FN_ADDRESS))
        begin
            ptr_r <= req.wdata;                                                  // [RULE2] [RULE1]
        end
        else if (ptr_step)
        begin
            // wraps at the top of the 16-bit space
            ptr_r <= ptr_r + mmdir_pkg::PTR_STEP;                                // [RULE14] [RULE9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // extended storage: data modes store at the current pointer; the step
    // above lands on the same edge, so this write still uses the old pointer
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            for (int i = 0; i < EXT_WORDS; i++)
            begin
                ext_r[i] <= mmdir_pkg::EXT_RESET;
            end
        end
        else if (data_hit && req.wr && (fn_r != mmdir_pkg::FN_ADDRESS)
                 && ext_target(ptr_r))
        begin
            ext_r[ext_index(ptr_r)] <= req.wdata;                                // [RULE5] [RULE7]
        end
    end

endmodule // mmdir_indirect_regs

// [mmdir_indirect_regs_monitor.sv]
`timescale 1ns/100ps

module mmdir_indirect_regs_monitor
#(
    parameter int EXT_WORDS = 32          // kept in step with the design
)
(
    input wire logic       i_clock,       // system clock
    input wire logic       i_reset_n,     // async reset, active low
    input wire logic       i_mdc,         // management clock pin
    input wire logic       i_mdio,        // resolved data pin
    input wire logic [4:0] i_phy_addr,    // address straps
    input wire logic       o_mdio,        // data pin, output side
    input wire logic       o_mdio_oe      // data pin enable
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] mdc_q;                    // sampled management clock history
    logic [3:0] since_r;                  // cycles since the last clock rise
    logic [4:0] rises_r;                  // clock rises seen while driving
    logic       mdc_rise;                 // one cycle per clock rise
    assign mdc_rise = mdc_q[0] & ~mdc_q[1];

    // one stage only, so a rise is seen before the design can react
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n) mdc_q <= 2'h0;
        else mdc_q <= {mdc_q[0], i_mdc};
    end

    // saturating age of the last rise
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n) since_r <= 4'hF;
        else if (mdc_rise) since_r <= 4'h0;
        else if (since_r != 4'hF) since_r <= since_r + 4'h1;
    end

    // bit times of one driven answer
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n) rises_r <= 5'h00;
        else if (!o_mdio_oe) rises_r <= 5'h00;
        else if (mdc_rise) rises_r <= rises_r + 5'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    a_reset_quiet: assert property ($rose(i_reset_n) |-> !o_mdio_oe [*3])
        else $error("pin driven right after reset");
    a_idle_high: assert property (!o_mdio_oe |-> o_mdio)
        else $error("output not high while released");
    a_ta_zero: assert property ($rose(o_mdio_oe) |-> !o_mdio [*3])
        else $error("turnaround bit not low");
    a_data_len: assert property ($fell(o_mdio_oe) |-> rises_r == 5'd17)
        else $error("read answer not seventeen bit times");
    a_out_edge: assert property ($changed(o_mdio) |-> since_r <= 4'd3)
        else $error("data output moved away from a clock rise");
    a_oe_edge: assert property ($changed(o_mdio_oe) |-> since_r <= 4'd3)
        else $error("enable moved away from a clock rise");
    a_oe_width: assert property ($rose(o_mdio_oe) |-> o_mdio_oe [*8])
        else $error("enable pulse too short");
    a_release_high: assert property ($fell(o_mdio_oe) |-> o_mdio)
        else $error("output not returned high on release");

    c_answer: cover property ($rose(o_mdio_oe));
    c_release: cover property ($fell(o_mdio_oe) && rises_r == 5'd17);
    c_restart: cover property ($rose(i_reset_n));

endmodule // mmdir_indirect_regs_monitor

bind mmdir_indirect_regs mmdir_indirect_regs_monitor #(.EXT_WORDS(EXT_WORDS)) u_mon
(
    .i_clock    (i_clock),
    .i_reset_n  (i_reset_n),
    .i_mdc      (i_mdc),
    .i_mdio     (i_mdio),
    .i_phy_addr (i_phy_addr),
    .o_mdio     (o_mdio),
    .o_mdio_oe  (o_mdio_oe)
);

// [mmdir_indirect_regs_tb_top.sv]
`timescale 1ns/100ps

module mmdir_indirect_regs_tb_top;
    typedef struct packed {
        logic        rd;                  // read when set, else write
        logic [4:0]  ra;                  // direct register address
        logic [15:0] d;                   // write data or expected read data
    } mmdir_row_s;

    localparam logic       W     = 1'b0;
    localparam logic       R     = 1'b1;
    localparam logic [4:0] C     = mmdir_pkg::REG_MMD_ACCESS_CONTROL;
    localparam logic [4:0] A     = mmdir_pkg::REG_MMD_ADDRESS_DATA;
    localparam logic [4:0] PHY   = 5'h01;  // strapped bus address
    localparam int         LIMIT = 60000;  // 56 frames of 613 cycles, margin
    // ordinary traffic, in order
    localparam mmdir_row_s ROWS [50] = '{
        '{R,C,16'h0000}, '{W,A,16'h1234}, '{W,C,16'h001F}, '{R,C,16'h001F},
        '{R,A,16'h0000}, '{W,A,16'h0005}, '{W,A,16'h0003}, '{R,A,16'h0003},
        '{R,A,16'h0003}, '{W,C,16'h401F}, '{W,A,16'hAAAA}, '{W,A,16'hBBBB},
        '{R,A,16'hBBBB}, '{R,A,16'hBBBB}, '{W,C,16'h801F}, '{W,A,16'h1111},
        '{W,A,16'h2222}, '{W,C,16'h001F}, '{R,A,16'h0005}, '{W,A,16'h0003},
        '{W,C,16'h801F}, '{R,A,16'h1111}, '{R,A,16'h2222}, '{R,A,16'h0000},
        '{W,C,16'hC01F}, '{W,A,16'h3333}, '{R,A,16'h0000}, '{R,A,16'h0000},
        '{W,C,16'h001F}, '{R,A,16'h0007}, '{W,C,16'h401E}, '{W,A,16'h5555},
        '{R,C,16'h401E}, '{W,C,16'h401F}, '{R,A,16'h0000}, '{W,C,16'h001F},
        '{W,A,16'h001F}, '{W,C,16'h401F}, '{W,A,16'h7777}, '{R,A,16'h7777},
        '{W,C,16'h001F}, '{W,A,16'h000D}, '{W,C,16'h401F}, '{W,A,16'hFFFF},
        '{R,A,16'h0000}, '{R,C,16'h401F}, '{W,C,16'h001F}, '{W,A,16'h0006},
        '{W,C,16'h401F}, '{R,A,16'h3333}};

    ////////////////////////////////////////////////////////////////////////////
    logic        clock;                   // 100 MHz system clock
    logic        reset_n;                 // async reset, active low
    logic        mdc;                     // management clock from the station
    logic        dut_mdio;                // design data output
    logic        dut_oe;                  // design data enable
    logic        st_mdio;                 // station data output
    logic        st_oe;                   // station data enable
    logic        mdio_wire;               // resolved line, pull-up when idle
    logic [4:0]  phy_addr;                // address straps
    logic [15:0] q;                       // last read word
    int          n_errors = 0;            // mismatches
    int          n_checks = 0;            // comparisons made
    int          cycles = 0;              // run length guard

    assign mdio_wire = dut_oe ? dut_mdio : (st_oe ? st_mdio : 1'b1);

    mmdir_indirect_regs #(.EXT_WORDS(32)) uut
    (
        .i_clock    (clock),
        .i_reset_n  (reset_n),
        .i_mdc      (mdc),
        .i_mdio     (mdio_wire),
        .i_phy_addr (phy_addr),
        .o_mdio     (dut_mdio),
        .o_mdio_oe  (dut_oe)
    );

    mmdir_station st
    (
        .i_mdio_wire (mdio_wire),
        .o_mdc       (mdc),
        .o_mdio      (st_mdio),
        .o_mdio_oe   (st_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    always #5 clock = ~clock;

    // cut a hang short
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_errors++;
            $display("MISMATCH run length expected %0d seen %0d", LIMIT, cycles);
            test_done();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        reset_n = 1'b0;
        phy_addr = PHY;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        // bus kept quiet for more than one bit time after release
        repeat (20) @(posedge clock);
        foreach (ROWS[i])
        begin
            st.frame(ROWS[i].rd, PHY, ROWS[i].ra, ROWS[i].d, q);
            if (ROWS[i].rd)
                check("table read", ROWS[i].d, q);
        end
        // another bus address: nobody answers, the pull-up reads back
        st.frame(R, PHY + 5'h01, C, 16'h0000, q);
        check("foreign address", 16'hFFFF, q);
        // abort between the mode write and the data access
        st.frame(W, PHY, C, 16'h801F, q);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (20) @(posedge clock);
        st.frame(R, PHY, C, 16'h0000, q);
        check("control after reset", 16'h0000, q);
        st.frame(R, PHY, A, 16'h0000, q);
        check("data with device zero", 16'h0000, q);
        st.frame(W, PHY, C, 16'h001F, q);
        st.frame(R, PHY, A, 16'h0000, q);
        check("pointer after reset", 16'h0000, q);
        test_done();
    end

endmodule // mmdir_indirect_regs_tb_top

// [mmdir_mdio_slave.sv]
`timescale 1ns/100ps

module mmdir_mdio_slave
(
    input  wire logic               i_clock,     // system clock
    input  wire logic               i_reset_n,   // async reset, active low
    input  wire logic               i_mdc,       // management clock pin
    input  wire logic               i_mdio,      // management data pin, input side
    input  wire logic [4:0]         i_phy_addr,  // own bus address
    input  wire logic [15:0]        i_rdata,     // read data, valid with o_req.rd
    output logic                    o_mdio,      // management data pin, output side
    output logic                    o_mdio_oe,   // high while driving the pin
    output mmdir_pkg::mmdir_req_s   o_req        // decoded transaction
);

    ////////////////////////////////////////////////////////////////////////////
    // frame states
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_HDR, ST_TA, ST_DATA} mmdir_frame_e;

    logic [2:0]   mdc_sync_r;   // two sync stages plus edge history
    logic [1:0]   mdio_sync_r;  // two sync stages
    logic         mdc_rise;     // one cycle per rising edge of the link clock
    logic         bit_in;       // synchronised data bit
    mmdir_frame_e state_r;      // frame position
    logic [4:0]   cnt_r;        // bit counter within a field
    logic [15:0]  rx_r;         // incoming bits
    logic [15:0]  tx_r;         // outgoing read data
    logic         do_rd_r;      // frame is a read addressed to us
    logic         do_wr_r;      // frame is a write addressed to us

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers; edge detection only looks at the second stage onward
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mdc_sync_r  <= 3'h0;
            mdio_sync_r <= 2'h3;   // idle line is pulled high
        end
        else
        begin
            mdc_sync_r  <= {mdc_sync_r[1:0], i_mdc};
            mdio_sync_r <= {mdio_sync_r[0], i_mdio};
        end
    end

    assign mdc_rise = mdc_sync_r[1] & ~mdc_sync_r[2];
    assign bit_in   = mdio_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // frame engine: all steps happen on a detected rising edge of the link clock;
    // the clock may stop between frames, so nothing here waits on an idle edge
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r   <= ST_IDLE;
            cnt_r     <= mmdir_pkg::CNT_ZERO;
            rx_r      <= mmdir_pkg::READ_ZERO;
            tx_r      <= '1; // idles high
            do_rd_r   <= 1'b0;
            do_wr_r   <= 1'b0;
            o_mdio    <= 1'b1;
            o_mdio_oe <= 1'b0;
            o_req     <= '0;
        end
        else
        begin
            o_req.rd <= 1'b0;
            o_req.wr <= 1'b0;
            if (o_req.rd)
            begin
                tx_r <= i_rdata;   // bank answers in the cycle of the pulse
            end
            if (mdc_rise)
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        // first start bit is a zero after the high idle line
                        if (!bit_in)
                        begin
                            state_r <= ST_START;
                        end
                    end
                    ST_START:
                    begin
                        // second start bit; repeated zeros keep waiting
                        if (bit_in)
                        begin
                            state_r <= ST_HDR;
                            cnt_r   <= mmdir_pkg::CNT_ZERO;
                        end
                    end
                    ST_HDR:
                    begin
                        rx_r  <= {rx_r[14:0], bit_in};
                        cnt_r <= cnt_r + mmdir_pkg::CNT_ONE;
                        if (cnt_r == mmdir_pkg::HDR_LAST)
                        begin
                            // rx_r[10:0] plus this bit: op, phy address, reg address
                            state_r        <= ST_TA;
                            cnt_r          <= mmdir_pkg::CNT_ZERO;
                            o_req.reg_addr <= {rx_r[3:0], bit_in};
                            if (rx_r[8:4] == i_phy_addr)
                            begin
                                do_rd_r  <= (rx_r[10:9] == mmdir_pkg::OP_READ);
                                do_wr_r  <= (rx_r[10:9] == mmdir_pkg::OP_WRITE);
                                o_req.rd <= (rx_r[10:9] == mmdir_pkg::OP_READ);
                            end
                            else
                            begin
                                // other address: ride out the frame silently
                                do_rd_r <= 1'b0;
                                do_wr_r <= 1'b0;
                            end
                        end
                    end
                    ST_TA:
                    begin
                        cnt_r <= cnt_r + mmdir_pkg::CNT_ONE;
                        if (cnt_r == mmdir_pkg::CNT_ZERO)
                        begin
                            // first turnaround bit left floating, drive zero for the second
                            o_mdio    <= !do_rd_r;
                            o_mdio_oe <= do_rd_r;
                        end
                        else
                        begin
                            state_r <= ST_DATA;
                            cnt_r   <= mmdir_pkg::CNT_ZERO;
                            o_mdio  <= tx_r[15];
                            tx_r    <= {tx_r[14:0], 1'b1};
                        end
                    end
                    ST_DATA:
                    begin
                        rx_r  <= {rx_r[14:0], bit_in};
                        cnt_r <= cnt_r + mmdir_pkg::CNT_ONE;
                        if (cnt_r == mmdir_pkg::DATA_LAST)
                        begin
                            state_r   <= ST_IDLE;
                            o_mdio    <= 1'b1;
                            o_mdio_oe <= 1'b0;
                            o_req.wr  <= do_wr_r;
                            o_req.wdata <= {rx_r[14:0], bit_in};
                        end
                        else
                        begin
                            o_mdio <= tx_r[15];
                            tx_r   <= {tx_r[14:0], 1'b1};
                        end
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // mmdir_mdio_slave

// [mmdir_pkg.sv]
package mmdir_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // directly addressed management registers
    localparam logic [4:0]  REG_MMD_ACCESS_CONTROL = 5'h0D; // function + device number
    localparam logic [4:0]  REG_MMD_ADDRESS_DATA   = 5'h0E; // pointer or extended data

    // access-control field layout
    localparam int          FN_HI        = 15;
    localparam int          FN_LO        = 14;
    localparam int          DEVNUM_HI    = 4;
    localparam int          DEVNUM_LO    = 0;
    localparam int          RSVD_WIDTH   = FN_LO - DEVNUM_HI - 1; // bits 13:5 read zero

    // the only device number this block answers to
    localparam logic [4:0]  DEVNUM_MMD   = 5'h1F;

    // function field encodings
    localparam logic [1:0]  FN_ADDRESS   = 2'h0; // address/data reaches the pointer
    localparam logic [1:0]  FN_DATA      = 2'h1; // data, pointer held
    localparam logic [1:0]  FN_INC_RW    = 2'h2; // data, advance after reads and writes
    localparam logic [1:0]  FN_INC_WR    = 2'h3; // data, advance after writes only

    // reset values, zero read word and pointer step
    localparam logic [1:0]  FN_RESET     = 2'h0;
    localparam logic [4:0]  DEVNUM_RESET = 5'h00;
    localparam logic [15:0] PTR_RESET    = 16'h0000;
    localparam logic [15:0] EXT_RESET    = 16'h0000;
    localparam logic [15:0] READ_ZERO    = 16'h0000;
    localparam logic [15:0] PTR_STEP     = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // serial management frame
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam logic [1:0]  OP_READ      = 2'h2;
    localparam logic [4:0]  HDR_LAST     = 5'h0B; // op(2) + phy(5) + reg(5) bits, minus one
    localparam logic [4:0]  DATA_LAST    = 5'h0F; // sixteen data bits, minus one
    localparam logic [4:0]  CNT_ZERO     = 5'h00;
    localparam logic [4:0]  CNT_ONE      = 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    // one decoded management transaction, handed from frame engine to bank
    typedef struct packed {
        logic        rd;       // one-cycle pulse: read taken, data sampled now
        logic        wr;       // one-cycle pulse: write with full data word
        logic [4:0]  reg_addr; // direct register address of the frame
        logic [15:0] wdata;    // write data
    } mmdir_req_s;

endpackage

// [mmdir_station.sv]
`timescale 1ns/100ps

module mmdir_station
(
    input  wire logic i_mdio_wire,        // resolved data line
    output logic      o_mdc,              // management clock, still between frames
    output logic      o_mdio,             // value the station drives
    output logic      o_mdio_oe           // high while the station drives
);
    // idle: clock low, line released to the pull-up
    initial
    begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
    end

    // one bit time of 125 ns: change in the low phase, sample at the rise
    task automatic bit_time(input logic drv, input logic val, output logic seen);
        o_mdio_oe = drv;
        o_mdio = val;
        #62.5;
        o_mdc = 1'b1;
        seen = i_mdio_wire;
        #62.5;
        o_mdc = 1'b0;
    endtask

    // whole frame; a read releases the line from the turnaround on
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [31:0] head;                // preamble, start, op, addresses, turnaround
        logic        s;                   // sample nobody needs
        head = {16'hFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10};
        #1; // clear of clock edges
        for (int i = 31; i >= 2; i--) bit_time(1'b1, head[i], s);
        for (int i = 1; i >= 0; i--) bit_time(!rd, head[i], s);
        for (int i = 15; i >= 0; i--) bit_time(!rd, wd[i], q[i]);
        bit_time(1'b0, 1'b1, s);
        #4;
    endtask

endmodule // mmdir_station
